// File: design/cc_channel_consts.svh
/*
 * Constants for the standard capture/compare channel: mode field codes,
 * timer configuration codes, prescale counts and widths.
 * Assumes inclusion by bare name from design files.
 */
`ifndef CC_CHANNEL_CONSTS_SVH
`define CC_CHANNEL_CONSTS_SVH

// ----------------------------------------------------------------------
// Mode field codes
// ----------------------------------------------------------------------
`define MODE_OFF 4'h0
`define MODE_CMP_TOGGLE 4'h2
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLR 4'h9
`define MODE_CMP_SOFT 4'hA

// ----------------------------------------------------------------------
// Prescale counts and widths
// ----------------------------------------------------------------------
`define PRESCALE_4 4'h3
`define PRESCALE_16 4'hF
`define COUNT_WIDTH 16
`define MODE_WIDTH 4

// ----------------------------------------------------------------------
// Timer configuration codes (alt control enable bits)
// ----------------------------------------------------------------------
`define TCFG_ALL_PRIMARY 2'b00
`define TCFG_ENH_ONE 2'b01
`define TCFG_ENH_ONE_TWO 2'b10
`define TCFG_ALL_ALTERNATE 2'b11

`endif

// File: design/cc_channel_pkg.sv
/*
 * Types shared by the capture/compare channel files.
 * Assumes the constants header is compiled alongside.
 */
`default_nettype none

package cc_channel_pkg;

    typedef enum logic [1:0] {
        CLASS_OFF,
        CLASS_CAPTURE,
        CLASS_COMPARE,
        CLASS_PWM
    } mode_class_t;

    typedef enum logic [1:0] {
        CH_ENH_ONE,
        CH_ENH_TWO,
        CH_STANDARD
    } channel_id_t;

endpackage

`default_nettype wire

// File: design/edge_qualifier.sv
/*
 * Pin synchroniser, edge detector and capture prescaler for one channel.
 * Assumes pin level is sampled whatever the pin direction.
 */
`include "cc_channel_consts.svh"

`default_nettype none

module edge_qualifier (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic pin_level,
    input wire logic [3:0] mode,
    output logic capture_event
);

    // ------------------------------------------------------------------
    // Synchroniser and edge detect
    // ------------------------------------------------------------------
    logic sync1_reg, sync2_reg, prev_reg;
    logic [3:0] presc_reg, presc_next;
    logic rise, fall, is_capture;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
            presc_reg <= 4'h0;
        end else begin
            sync1_reg <= pin_level;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            presc_reg <= presc_next;
        end
    end

    assign rise = sync2_reg && !prev_reg;
    assign fall = !sync2_reg && prev_reg;
    assign is_capture = (mode[3:2] == 2'b01);

    // ------------------------------------------------------------------
    // Prescaler; a direct change between capture codes keeps the count
    // ------------------------------------------------------------------
    always_comb begin
        presc_next = presc_reg;
        capture_event = 1'b0;
        if (!is_capture) begin
            presc_next = 4'h0;
        end else begin
            case (mode)
                `MODE_CAP_FALL: capture_event = fall;
                `MODE_CAP_RISE: capture_event = rise;
                `MODE_CAP_RISE4: begin
                    if (rise) begin
                        presc_next = (presc_reg >= `PRESCALE_4) ? 4'h0
                                     : presc_reg + 4'h1;
                        capture_event = (presc_reg >= `PRESCALE_4);
                    end
                end
                `MODE_CAP_RISE16: begin
                    if (rise) begin
                        presc_next = presc_reg + 4'h1;
                        capture_event = (presc_reg == `PRESCALE_16);
                    end
                end
                default: capture_event = 1'b0;
            endcase
        end
    end

endmodule

`default_nettype wire

// File: design/capture_compare_channel.sv
/*
 * Standard capture/compare channel with timer routing.
 * Assumes the timers run elsewhere and are synchronous to ref_clk; the
 * interrupt enable/priority logic lives outside.
 */
// Behaviour
// - Capture/compare on cc timers, PWM on pwm timers
// - Timer routing from alt control enable bits
// - Config 0: all channels use primary timers
// - Config 1: only enhanced one uses primary
// - Config 2: enhanced one and two use primary
// - Config 3: all channels use alternate timers
// - Capture copies full 16-bit selected count
// - Falling, rising, 4th or 16th rising edge
// - Capture codes 0100 to 0111
// - Capture sets flag; only software clears
// - New capture overwrites unread result
// - Edge detection sees pin in output mode
// - Prescaler cleared when off or not capturing
// - Direct prescaler switch keeps count
// - Compare value against timer every cycle
// - Match drives, toggles or leaves pin, flags
// - Codes 0010 toggle, 1000 set, 1001 clear
// - Control write of zero forces latch low
// - Code 1010 only flags the match
// - No special event trigger on standard channel

`include "cc_channel_consts.svh"

`default_nettype none

module capture_compare_channel #(
    parameter int COUNT_W = `COUNT_WIDTH,
    parameter cc_channel_pkg::channel_id_t CHANNEL =
        cc_channel_pkg::CH_STANDARD
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    // Control register write
    input wire logic ctrl_wr,
    input wire logic [3:0] ctrl_wdata,
    // Value register writes, byte wide
    input wire logic low_wr,
    input wire logic high_wr,
    input wire logic [7:0] byte_wdata,
    // Flag clear from software
    input wire logic flag_clr,
    input wire logic channel_irq_enable,
    // Timer routing bits from the alternate timer control
    input wire logic [1:0] timer_cfg,
    input wire logic [COUNT_W-1:0] cc_timer_primary_count,
    input wire logic [COUNT_W-1:0] cc_timer_alternate_count,
    // Pin
    input wire logic channel_pin_in,
    input wire logic port_latch,
    output logic channel_pin_out,
    output logic [3:0] channel_mode_field,
    output logic [7:0] result_low_byte,
    output logic [7:0] result_high_byte,
    output logic channel_irq_flag,
    output logic irq_request,
    output logic use_alt_cc_timer,
    output logic use_alt_pwm_timer
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic cc_channel_pkg::mode_class_t classify(
        input logic [3:0] m);
        cc_channel_pkg::mode_class_t c;
        c = cc_channel_pkg::CLASS_OFF;
        if (m[3:2] == 2'b11) begin
            c = cc_channel_pkg::CLASS_PWM;
        end else if (m[3:2] == 2'b01) begin
            c = cc_channel_pkg::CLASS_CAPTURE;
        end else if (m == `MODE_CMP_TOGGLE || m == `MODE_CMP_SET ||
                     m == `MODE_CMP_CLR || m == `MODE_CMP_SOFT) begin
            c = cc_channel_pkg::CLASS_COMPARE;
        end
        return c;
    endfunction

    // Whether this channel falls on the alternate timer pair
    function automatic logic pick_alt(input logic [1:0] cfg);
        logic alt;
        alt = 1'b0;
        case (cfg)
            `TCFG_ALL_PRIMARY: alt = 1'b0;
            `TCFG_ENH_ONE:
                alt = (CHANNEL != cc_channel_pkg::CH_ENH_ONE);
            `TCFG_ENH_ONE_TWO:
                alt = (CHANNEL == cc_channel_pkg::CH_STANDARD);
            `TCFG_ALL_ALTERNATE: alt = 1'b1;
            default: alt = 1'b0;
        endcase
        return alt;
    endfunction

    // Codes in which the compare latch owns the pin; PWM and reserved
    // codes leave it to the port latch
    function automatic logic drives_pin(input logic [3:0] m);
        logic d;
        d = 1'b0;
        case (m)
            `MODE_CMP_TOGGLE, `MODE_CMP_SET, `MODE_CMP_CLR: d = 1'b1;
            default: d = 1'b0;
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [3:0] mode_reg, mode_next;
    logic [COUNT_W-1:0] value_reg, value_next;
    logic flag_reg, flag_next;
    logic out_latch_reg, out_latch_next;
    logic pin_reg, pin_next;
    logic irq_reg, irq_next;
    logic alt_reg, alt_next;
    logic [COUNT_W-1:0] timer_sel;
    logic capture_event;
    logic match;
    cc_channel_pkg::mode_class_t cls;

    edge_qualifier u_edge (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pin_level(channel_pin_in),
        .mode(mode_reg),
        .capture_event(capture_event)
    );

    assign cls = classify(mode_reg);
    // Capture and compare share the cc timer selected by routing
    assign timer_sel = alt_reg ? cc_timer_alternate_count
                               : cc_timer_primary_count;
    assign match = (cls == cc_channel_pkg::CLASS_COMPARE) &&
                   (value_reg == timer_sel);

    // ------------------------------------------------------------------
    // Timer routing
    // ------------------------------------------------------------------
    // Registered, so a routing change reaches the timer select one cycle
    // later; software changes routing while the channel is off
    always_comb begin
        alt_next = pick_alt(timer_cfg);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            alt_reg <= 1'b0;
        end else begin
            alt_reg <= alt_next;
        end
    end

    // ------------------------------------------------------------------
    // Mode field and compare output latch
    // ------------------------------------------------------------------
    always_comb begin
        mode_next = mode_reg;
        out_latch_next = out_latch_reg;
        if (match) begin
            case (mode_reg)
                `MODE_CMP_TOGGLE: out_latch_next = !out_latch_reg;
                `MODE_CMP_SET: out_latch_next = 1'b1;
                `MODE_CMP_CLR: out_latch_next = 1'b0;
                default: out_latch_next = out_latch_reg;
            endcase
        end
        // The write lands after the match, so a zero write leaves the
        // latch low even when a match falls in the same cycle
        if (ctrl_wr) begin
            mode_next = ctrl_wdata;
            // Entering a set/clear mode initialises the latch
            case (ctrl_wdata)
                `MODE_OFF: out_latch_next = 1'b0;
                `MODE_CMP_SET: out_latch_next = 1'b0;
                `MODE_CMP_CLR: out_latch_next = 1'b1;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= 4'h0;
            out_latch_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            out_latch_reg <= out_latch_next;
        end
    end

    // ------------------------------------------------------------------
    // Channel value: software bytes or captured count
    // ------------------------------------------------------------------
    always_comb begin
        value_next = value_reg;
        // Bytes land one at a time; there is no high-byte buffer
        if (low_wr) begin
            value_next[7:0] = byte_wdata;
        end
        if (high_wr) begin
            value_next[COUNT_W-1:8] = byte_wdata[COUNT_W-9:0];
        end
        // No overrun guard: a new capture replaces an unread result and
        // beats a byte write in the same cycle
        if (capture_event) begin
            value_next = timer_sel;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            value_reg <= '0;
        end else begin
            value_reg <= value_next;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt flag
    // ------------------------------------------------------------------
    always_comb begin
        flag_next = flag_reg;
        // Sticky: only a software clear takes it down
        // Hardware event wins over a software clear in the same cycle
        if (flag_clr) begin
            flag_next = 1'b0;
        end
        if (capture_event) begin
            flag_next = 1'b1;
        end
        if (match) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // ------------------------------------------------------------------
    // Pin
    // ------------------------------------------------------------------
    // Pin: compare latch in pin-driving modes, otherwise the port latch.
    // No trigger output exists on this channel.
    always_comb begin
        pin_next = port_latch;
        if (drives_pin(mode_next)) begin
            pin_next = out_latch_next;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= pin_next;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------
    // Registered with the flag so the request is a clean flop output
    always_comb begin
        irq_next = flag_next && channel_irq_enable;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign channel_pin_out = pin_reg;
    assign channel_mode_field = mode_reg;
    assign result_low_byte = value_reg[7:0];
    assign result_high_byte = value_reg[15:8];
    assign channel_irq_flag = flag_reg;
    assign irq_request = irq_reg;
    // PWM time base follows the same routing as capture/compare
    assign use_alt_cc_timer = alt_reg;
    assign use_alt_pwm_timer = alt_reg;

endmodule

`default_nettype wire

// File: sim/pin_source.sv
/* Far-side model of the channel pin: a source that drives the pin.
 * Assumes the bench commands it between clock edges. */
`default_nettype none
module pin_source (
    input wire logic drive_en,
    input wire logic drive_level,
    input wire logic chan_out,
    output logic pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released source lets the pin show the channel's own drive
    assign pin_level = drive_en ? drive_level : chan_out;
endmodule
`default_nettype wire

// File: sim/cc_channel_props.sv
/* Port checker for the capture/compare channel, bound at the foot.
 * Assumes the single ref_clk domain with reset arst_n. */
`default_nettype none
module cc_channel_props #(
    parameter int COUNT_W = 16
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ctrl_wr,
    input wire logic [3:0] ctrl_wdata,
    input wire logic flag_clr,
    input wire logic channel_irq_enable,
    input wire logic [1:0] timer_cfg,
    input wire logic [COUNT_W-1:0] cc_timer_primary_count,
    input wire logic [COUNT_W-1:0] cc_timer_alternate_count,
    input wire logic port_latch,
    input wire logic channel_pin_out,
    input wire logic [3:0] channel_mode_field,
    input wire logic [7:0] result_low_byte,
    input wire logic [7:0] result_high_byte,
    input wire logic channel_irq_flag,
    input wire logic irq_request,
    input wire logic use_alt_cc_timer,
    input wire logic use_alt_pwm_timer
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hit;
    assign hit = {result_high_byte, result_low_byte} == (use_alt_cc_timer
        ? cc_timer_alternate_count : cc_timer_primary_count);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    flag_hold_a: assert property (
        channel_irq_flag && !flag_clr |=> channel_irq_flag)
        else $error("flag fell without a clear");
    mode_write_a: assert property (
        ctrl_wr |=> channel_mode_field == $past(ctrl_wdata))
        else $error("mode field not written");
    mode_hold_a: assert property (
        !ctrl_wr |=> $stable(channel_mode_field))
        else $error("mode field changed without a write");
    route_sel_a: assert property (
        1'b1 |=> use_alt_cc_timer == ($past(timer_cfg) != 2'b00)
        && use_alt_pwm_timer == ($past(timer_cfg) != 2'b00))
        else $error("timer routing wrong");
    cmp_set_a: assert property (
        channel_mode_field == 4'h8 && hit && !ctrl_wr
        |=> channel_pin_out && channel_irq_flag)
        else $error("set on match failed");
    cmp_clr_a: assert property (
        channel_mode_field == 4'h9 && hit && !ctrl_wr
        |=> !channel_pin_out && channel_irq_flag)
        else $error("clear on match failed");
    cmp_toggle_a: assert property (
        channel_mode_field == 4'h2 && hit && !ctrl_wr
        |=> channel_pin_out != $past(channel_pin_out))
        else $error("toggle on match failed");
    soft_pin_a: assert property (
        channel_mode_field == 4'hA && !ctrl_wr ##1 $stable(port_latch)
        && $past(port_latch) == $past(port_latch, 2)
        |-> channel_pin_out == port_latch)
        else $error("pin left port latch in flag-only mode");
    zero_latch_a: assert property (
        ctrl_wr && ctrl_wdata == 4'h0 ##1 ctrl_wr && ctrl_wdata == 4'h2
        && !hit ##1 !hit |=> !channel_pin_out)
        else $error("zero write left compare latch high");
    irq_gate_a: assert property (
        irq_request |-> $past(channel_irq_enable))
        else $error("request without enable");
    cover property (channel_mode_field == 4'h7 && $rose(channel_irq_flag));
    cover property (channel_mode_field == 4'h2 && hit);
    cover property (irq_request);
endmodule
bind capture_compare_channel cc_channel_props #(.COUNT_W(COUNT_W)) i_props (
    .ref_clk(ref_clk), .arst_n(arst_n), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .flag_clr(flag_clr),
    .channel_irq_enable(channel_irq_enable), .timer_cfg(timer_cfg),
    .cc_timer_primary_count(cc_timer_primary_count),
    .cc_timer_alternate_count(cc_timer_alternate_count),
    .port_latch(port_latch), .channel_pin_out(channel_pin_out),
    .channel_mode_field(channel_mode_field),
    .result_low_byte(result_low_byte), .result_high_byte(result_high_byte),
    .channel_irq_flag(channel_irq_flag), .irq_request(irq_request),
    .use_alt_cc_timer(use_alt_cc_timer),
    .use_alt_pwm_timer(use_alt_pwm_timer)
);
`default_nettype wire

// File: sim/test_capture_compare_channel.sv
/* Self-checking bench for the standard capture/compare channel.
 * Assumes the bench sets both timer counts directly, with no timer running. */
`default_nettype none
module test_capture_compare_channel;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, arst_n = 1'b0, ctrl_wr = 1'b0, low_wr = 1'b0;
    logic high_wr = 1'b0, flag_clr = 1'b0, irq_en = 1'b0;
    logic [3:0] ctrl_wdata = 4'h0;
    logic [7:0] byte_wdata = 8'h00;
    logic [1:0] timer_cfg = 2'b00;
    logic [15:0] tmr_p = 16'h0000, tmr_a = 16'h0000, exp_v;
    logic port_latch = 1'b0, drive_en = 1'b1, drive_level = 1'b0;
    logic pin, pin_out, flag, irq_req, alt_cc, alt_pwm;
    logic [3:0] mode;
    logic [7:0] res_lo, res_hi;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;

    capture_compare_channel i_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .low_wr(low_wr), .high_wr(high_wr),
        .byte_wdata(byte_wdata), .flag_clr(flag_clr),
        .channel_irq_enable(irq_en), .timer_cfg(timer_cfg),
        .cc_timer_primary_count(tmr_p), .cc_timer_alternate_count(tmr_a),
        .channel_pin_in(pin), .port_latch(port_latch),
        .channel_pin_out(pin_out), .channel_mode_field(mode),
        .result_low_byte(res_lo), .result_high_byte(res_hi),
        .channel_irq_flag(flag), .irq_request(irq_req),
        .use_alt_cc_timer(alt_cc), .use_alt_pwm_timer(alt_pwm)
    );
    pin_source i_pin (.drive_en(drive_en), .drive_level(drive_level),
        .chan_out(pin_out), .pin_level(pin));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic final_report();
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A few hundred cycles are needed; anything far beyond is a hang
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic ctrl(input logic [3:0] m);
        ctrl_wdata = m;
        ctrl_wr = 1'b1;
        tick(1);
        ctrl_wr = 1'b0;
        tick(1);
    endtask

    task automatic clear_flag();
        flag_clr = 1'b1;
        tick(1);
        flag_clr = 1'b0;
        tick(1);
    endtask

    // Pulse widths of three cycles let the synchroniser see every edge
    task automatic pulse(input int n);
        repeat (n) begin
            drive_level = 1'b1;
            tick(3);
            drive_level = 1'b0;
            tick(3);
        end
        tick(2);
    endtask

    task automatic match_once();
        tmr_p = 16'h2468;
        tick(1);
        tmr_p = 16'h0000;
        tick(2);
    endtask

    initial begin
        tick(13);
        arst_n = 1'b1;
        tick(1);
        chk("result", {res_hi, res_lo}, 16'h0000);
        chk("flag", 16'(flag), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            timer_cfg = 2'(i);
            tmr_p = 16'hA5C3 ^ 16'(i);
            tmr_a = 16'h5A3C + 16'(i);
            exp_v = (i == 0) ? tmr_p : tmr_a;
            ctrl(4'h0);
            ctrl(4'h4 + 4'(i));
            clear_flag();
            chk("alt cc", 16'(alt_cc), 16'(i != 0));
            chk("alt pwm", 16'(alt_pwm), 16'(i != 0));
            pulse((i < 2) ? 0 : ((i == 2) ? 3 : 15));
            chk("early flag", 16'(flag), 16'h0000);
            pulse(1);
            chk("flag", 16'(flag), 16'h0001);
            chk("capture", {res_hi, res_lo}, exp_v);
        end
        ctrl(4'h6);
        pulse(2);
        ctrl(4'h0);
        ctrl(4'h6);
        clear_flag();
        pulse(3);
        chk("cleared prescale", 16'(flag), 16'h0000);
        pulse(3);
        ctrl(4'h7);
        clear_flag();
        pulse(13);
        chk("kept prescale", 16'(flag), 16'h0000);
        pulse(1);
        chk("kept prescale", 16'(flag), 16'h0001);
        timer_cfg = 2'b00;
        ctrl(4'h5);
        tmr_p = 16'h0F0F;
        pulse(1);
        tmr_p = 16'hF0F0;
        pulse(1);
        chk("overwrite", {res_hi, res_lo}, 16'hF0F0);
        clear_flag();
        drive_en = 1'b0;
        port_latch = 1'b1;
        tick(6);
        chk("port capture", 16'(flag), 16'h0001);
        drive_en = 1'b1;
        tmr_p = 16'h0000;
        byte_wdata = 8'h68;
        low_wr = 1'b1;
        tick(1);
        low_wr = 1'b0;
        high_wr = 1'b1;
        byte_wdata = 8'h24;
        tick(1);
        high_wr = 1'b0;
        ctrl(4'h8);
        chk("init low", 16'(pin_out), 16'h0000);
        clear_flag();
        match_once();
        chk("set pin", {pin_out, flag}, 16'h0003);
        ctrl(4'h9);
        chk("init high", 16'(pin_out), 16'h0001);
        clear_flag();
        match_once();
        chk("clr pin", {pin_out, flag}, 16'h0001);
        ctrl(4'h9);
        chk("latch high", 16'(pin_out), 16'h0001);
        ctrl_wdata = 4'h0;
        ctrl_wr = 1'b1;
        tick(1);
        ctrl_wdata = 4'h2;
        tick(1);
        ctrl_wr = 1'b0;
        tick(1);
        chk("zero latch", 16'(pin_out), 16'h0000);
        match_once();
        chk("toggle", 16'(pin_out), 16'h0001);
        ctrl(4'hA);
        chk("mode", 16'(mode), 16'h000A);
        port_latch = 1'b0;
        tick(2);
        chk("soft pin", 16'(pin_out), 16'h0000);
        clear_flag();
        match_once();
        chk("soft flag", {flag, irq_req}, 16'h0002);
        irq_en = 1'b1;
        tick(2);
        chk("request", 16'(irq_req), 16'h0001);
        clear_flag();
        ctrl(4'hC);
        match_once();
        chk("pwm no match", {flag, irq_req}, 16'h0000);
        final_report();
    end
endmodule
`default_nettype wire
